// ---- design/ldx_pkg.sv ----
package ldx_pkg;
  localparam logic [7:0] OP_PREFIX_EXT = 8'hed;
  localparam logic [7:0] OP_PREFIX_IX  = 8'hdd;
  localparam logic [7:0] OP_PREFIX_IY  = 8'hfd;
  localparam logic [7:0] OP_PUSH_AF    = 8'hf5;
  localparam logic [7:0] OP_SWAP_AF    = 8'h08;
  localparam logic [7:0] OP_SWAP_BANKS = 8'hd9;
  localparam logic [7:0] OP_LD_A_ABS   = 8'h3a;
  localparam logic [7:0] OP_ST_A_ABS   = 8'h32;
  localparam logic [7:0] OP_LD_HL_ABS  = 8'h2a;
  localparam logic [7:0] OP_ST_HL_ABS  = 8'h22;
  localparam logic [7:0] OP_ST_IDX_IMM = 8'h36;
  localparam logic [7:0] OP_COPY_UP    = 8'ha0;
  localparam logic [7:0] OP_COPY_RUP   = 8'hb0;
  localparam logic [7:0] OP_COPY_DN    = 8'ha8;
  localparam logic [7:0] OP_COPY_RDN   = 8'hb8;
  localparam logic [7:0] OP_SRCH_UP    = 8'ha1;
  localparam logic [7:0] OP_SRCH_RUP   = 8'hb1;
  localparam logic [7:0] OP_SRCH_DN    = 8'ha9;
  localparam logic [7:0] OP_SRCH_RDN   = 8'hb9;
  localparam int         MATCH_BIT     = 6;
  localparam logic [15:0] RESET_PC     = 16'h0000;
  localparam logic [15:0] RESET_SP     = 16'hffff;
endpackage

// ---- design/step16.sv ----
`timescale 1ns/1ps
module step16 (
  // value and direction
  input  wire logic [15:0] value,
  input  wire logic        down,
  // result
  output logic      [15:0] stepped
);
  assign stepped = down ? value - 16'h0001 : value + 16'h0001;
endmodule

// ---- design/load_exchange_block_ops.sv ----
`timescale 1ns/1ps
module load_exchange_block_ops
  import ldx_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // memory bus
  output logic      [15:0] mem_addr,
  output logic             mem_rd,
  output logic             mem_wr,
  output logic      [7:0]  mem_wdata,
  input  wire logic [7:0]  mem_rdata,
  // status
  output logic             opcode_fetch_cycle,
  output logic      [15:0] source_pointer_pair,
  output logic      [15:0] target_pointer_pair,
  output logic      [15:0] byte_count_pair,
  output logic      [15:0] accumulator_flags_pair
);
  typedef enum {S_FETCH, S_FETCH2, S_OPND, S_MEMRD, S_MEMWR, S_PUSH, S_POP,
                S_BLKRD, S_BLKWR} state_t;
  // read data stands during the mem_rd cycle and is taken at its closing edge
  state_t      st, next_st;
  logic [15:0] pc, next_pc, sp, next_sp, ix, next_ix, iy, next_iy;
  logic [15:0] hl, next_hl, de, next_de, bc, next_bc, af, next_af;
  logic [15:0] af_alt, next_af_alt, hl_alt, next_hl_alt;
  logic [15:0] de_alt, next_de_alt, bc_alt, next_bc_alt;
  logic [7:0]  op, next_op, pfx, next_pfx;
  logic [15:0] opnd, next_opnd;
  logic [1:0]  need, next_need, got, next_got;
  logic        hi, next_hi;
  logic [7:0]  blk_byte, next_blk_byte;
  logic [15:0] addr, next_addr;
  logic        rd, next_rd, wr, next_wr;
  logic [7:0]  wdat, next_wdat;
  logic [15:0] hl_step, de_step, bc_dec, sp_dec, sp_inc;
  logic        blk_down;
  logic [7:0]  blk_sel;
  logic [15:0] push_val;

  assign blk_down = op[3];
  step16 u_hl (.value(hl), .down(blk_down), .stepped(hl_step));
  step16 u_de (.value(de), .down(blk_down), .stepped(de_step));
  step16 u_bc (.value(bc), .down(1'b1), .stepped(bc_dec));
  step16 u_sd (.value(sp), .down(1'b1), .stepped(sp_dec));
  step16 u_si (.value(sp), .down(1'b0), .stepped(sp_inc));

  assign blk_sel  = op;
  assign push_val = (op[5:4] == 2'b11) ? af : (op[5:4] == 2'b00) ? bc :
                    (op[5:4] == 2'b01) ? de : (pfx == OP_PREFIX_IX) ? ix :
                    (pfx == OP_PREFIX_IY) ? iy : hl;

  // operand count for the current opcode; displacement counted before data
  function automatic logic [1:0] operands(input logic [7:0] p, input logic [7:0] o);
    logic idx;
    idx = (p == OP_PREFIX_IX) || (p == OP_PREFIX_IY);
    if (p == OP_PREFIX_EXT) begin
      operands = (o[7:6] == 2'b01 && o[2:0] == 3'b011) ? 2'd2 : 2'd0;
    end else if (o == OP_ST_IDX_IMM && idx) begin
      operands = 2'd2;
    end else if (o[7:6] == 2'b00 && o[2:0] == 3'b110) begin
      operands = 2'd1;
    end else if (o[7:6] == 2'b01 && idx && (o[2:0] == 3'b110 || o[5:3] == 3'b110)) begin
      operands = 2'd1;
    end else if (o == OP_LD_A_ABS || o == OP_ST_A_ABS || o == OP_LD_HL_ABS ||
                 o == OP_ST_HL_ABS || (o[7:6] == 2'b00 && o[3:0] == 4'h1)) begin
      operands = 2'd2;
    end else begin
      operands = 2'd0;
    end
  endfunction

  always_comb begin
    next_st = st; next_pc = pc; next_sp = sp; next_ix = ix; next_iy = iy;
    next_hl = hl; next_de = de; next_bc = bc; next_af = af;
    next_af_alt = af_alt; next_hl_alt = hl_alt; next_de_alt = de_alt;
    next_bc_alt = bc_alt; next_op = op; next_pfx = pfx; next_opnd = opnd;
    next_need = need; next_got = got; next_hi = hi; next_blk_byte = blk_byte;
    next_addr = addr; next_rd = 1'b0; next_wr = 1'b0; next_wdat = wdat;
    unique case (st)
      S_FETCH: begin
        if (rd) begin
          next_pc = pc + 16'h0001;
          next_op = mem_rdata;
          if (mem_rdata == OP_PREFIX_EXT || mem_rdata == OP_PREFIX_IX ||
              mem_rdata == OP_PREFIX_IY) begin
            next_pfx = mem_rdata;
            next_st  = S_FETCH2;
            next_rd  = 1'b1;
            next_addr = pc + 16'h0001;
          end else begin
            next_pfx  = 8'h00;
            next_need = operands(8'h00, mem_rdata);
            next_got  = 2'd0;
            next_st   = S_OPND;
          end
        end else begin
          next_rd = 1'b1;
          next_addr = pc;
        end
      end
      S_FETCH2: begin
        if (rd) begin
          next_pc   = pc + 16'h0001;
          next_op   = mem_rdata;
          next_need = operands(pfx, mem_rdata);
          next_got  = 2'd0;
          next_st   = S_OPND;
        end
      end
      S_OPND: begin
        if (rd) begin
          next_pc  = pc + 16'h0001;
          // first byte low, second byte high
          if (got == 2'd0) next_opnd = {8'h00, mem_rdata};
          else next_opnd = {mem_rdata, opnd[7:0]};
          next_got = got + 2'd1;
        end else if (got < need) begin
          next_rd = 1'b1;
          next_addr = pc;
        end else begin
          next_st = S_FETCH;
          if (pfx == OP_PREFIX_EXT && op[7:5] == 3'b101 && op[2:1] == 2'b00) begin
            next_st = S_BLKRD;
            next_rd = 1'b1;
            next_addr = hl;
          end else if (pfx == 8'h00 && op == OP_SWAP_AF) begin
            next_af = af_alt; next_af_alt = af;
          end else if (pfx == 8'h00 && op == OP_SWAP_BANKS) begin
            next_bc = bc_alt; next_bc_alt = bc;
            next_de = de_alt; next_de_alt = de;
            next_hl = hl_alt; next_hl_alt = hl;
          end else if (op[7:6] == 2'b11 && op[3:0] == 4'h5) begin
            next_st = S_PUSH; next_hi = 1'b1;
          end else if (op[7:6] == 2'b11 && op[3:0] == 4'h1) begin
            next_st = S_POP; next_hi = 1'b0;
          end else if (op[7:6] == 2'b00 && op[3:0] == 4'h1 && pfx != OP_PREFIX_EXT) begin
            unique case (op[5:4])
              2'b00: next_bc = opnd;
              2'b01: next_de = opnd;
              2'b10: if (pfx == OP_PREFIX_IX) next_ix = opnd;
                     else if (pfx == OP_PREFIX_IY) next_iy = opnd;
                     else next_hl = opnd;
              2'b11: next_sp = opnd;
            endcase
          end else if (op[7:6] == 2'b00 && op[2:0] == 3'b110 && pfx == 8'h00 &&
                       op[5:3] == 3'b111) begin
            next_af = {opnd[7:0], af[7:0]};
          end else if (op[7:6] == 2'b00 && op[2:0] == 3'b110 && pfx == 8'h00) begin
            unique case (op[5:3])
              3'b000: next_bc = {opnd[7:0], bc[7:0]};
              3'b001: next_bc = {bc[15:8], opnd[7:0]};
              3'b010: next_de = {opnd[7:0], de[7:0]};
              3'b011: next_de = {de[15:8], opnd[7:0]};
              3'b100: next_hl = {opnd[7:0], hl[7:0]};
              3'b101: next_hl = {hl[15:8], opnd[7:0]};
              default: ;
            endcase
          end else if (op == OP_LD_A_ABS && pfx == 8'h00) begin
            next_st = S_MEMRD; next_rd = 1'b1; next_addr = opnd;
          end else if (op == OP_ST_A_ABS && pfx == 8'h00) begin
            next_st = S_MEMWR; next_wr = 1'b1; next_addr = opnd;
            next_wdat = af[15:8];
          end
        end
      end
      S_MEMRD: begin
        if (rd) begin
          next_af = {mem_rdata, af[7:0]};
          next_st = S_FETCH;
        end
      end
      S_MEMWR: next_st = S_FETCH;
      S_PUSH: begin
        // predecrement, high byte first
        next_sp = sp_dec;
        next_addr = sp_dec;
        next_wr = 1'b1;
        next_wdat = hi ? push_val[15:8] : push_val[7:0];
        next_hi = 1'b0;
        if (!hi) next_st = S_MEMWR;
      end
      S_POP: begin
        // read then postincrement, low byte first
        if (rd) begin
          next_sp = sp_inc;
          if (!hi) begin
            next_opnd = {8'h00, mem_rdata};
            next_hi = 1'b1;
          end else begin
            next_st = S_FETCH;
            unique case (op[5:4])
              2'b00: next_bc = {mem_rdata, opnd[7:0]};
              2'b01: next_de = {mem_rdata, opnd[7:0]};
              2'b10: if (pfx == OP_PREFIX_IX) next_ix = {mem_rdata, opnd[7:0]};
                     else if (pfx == OP_PREFIX_IY) next_iy = {mem_rdata, opnd[7:0]};
                     else next_hl = {mem_rdata, opnd[7:0]};
              2'b11: next_af = {mem_rdata, opnd[7:0]};
            endcase
          end
        end else begin
          next_rd = 1'b1;
          next_addr = sp;
        end
      end
      S_BLKRD: begin
        if (rd) begin
          next_blk_byte = mem_rdata;
          next_hl = hl_step;
          next_bc = bc_dec;
          if (blk_sel[0]) begin
            // search: match flag, stop on match or zero
            next_af = {af[15:8], af[7:MATCH_BIT+1], (mem_rdata == af[15:8]),
                       af[MATCH_BIT-1:0]};
            if (blk_sel[4] && bc_dec != 16'h0000 && mem_rdata != af[15:8]) begin
              next_rd = 1'b1;
              next_addr = hl_step;
            end else begin
              next_st = S_FETCH;
            end
          end else begin
            next_st = S_BLKWR;
            next_wr = 1'b1;
            next_addr = de;
            next_wdat = mem_rdata;
          end
        end
      end
      S_BLKWR: begin
        next_de = de_step;
        // byte-wise order keeps any overlap well defined
        if (blk_sel[4] && bc != 16'h0000) begin
          next_st = S_BLKRD;
          next_rd = 1'b1;
          next_addr = hl;
        end else begin
          next_st = S_FETCH;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st <= S_FETCH; pc <= RESET_PC; sp <= RESET_SP; ix <= '0; iy <= '0;
      hl <= '0; de <= '0; bc <= '0; af <= '0;
      af_alt <= '0; hl_alt <= '0; de_alt <= '0; bc_alt <= '0;
      op <= '0; pfx <= '0; opnd <= '0; need <= '0; got <= '0; hi <= 1'b0;
      blk_byte <= '0; addr <= '0; rd <= 1'b0; wr <= 1'b0; wdat <= '0;
      opcode_fetch_cycle <= 1'b0;
    end else begin
      st <= next_st; pc <= next_pc; sp <= next_sp; ix <= next_ix; iy <= next_iy;
      hl <= next_hl; de <= next_de; bc <= next_bc; af <= next_af;
      af_alt <= next_af_alt; hl_alt <= next_hl_alt; de_alt <= next_de_alt;
      bc_alt <= next_bc_alt; op <= next_op; pfx <= next_pfx; opnd <= next_opnd;
      need <= next_need; got <= next_got; hi <= next_hi; blk_byte <= next_blk_byte;
      addr <= next_addr; rd <= next_rd; wr <= next_wr; wdat <= next_wdat;
      opcode_fetch_cycle <= next_rd && (next_st == S_FETCH || next_st == S_FETCH2);
    end
  end

  assign mem_addr = addr;
  assign mem_rd = rd;
  assign mem_wr = wr;
  assign mem_wdata = wdat;
  assign source_pointer_pair = hl;
  assign target_pointer_pair = de;
  assign byte_count_pair = bc;
  assign accumulator_flags_pair = af;

  chk_push_high_first: assert property (@(posedge mclk) disable iff (!resetn)
    (st == S_PUSH && hi) |=> (mem_wr && mem_wdata == $past(push_val[15:8])))
    else $error("push did not write high byte first");
  chk_push_predec: assert property (@(posedge mclk) disable iff (!resetn)
    (st == S_PUSH) |=> (mem_addr == $past(sp) - 16'h0001 && sp == mem_addr))
    else $error("stack pointer not predecremented");
  chk_swap_af: assert property (@(posedge mclk) disable iff (!resetn)
    (st == S_OPND && !rd && got >= need && pfx == 8'h00 && op == OP_SWAP_AF)
    |=> (af == $past(af_alt) && af_alt == $past(af)))
    else $error("accumulator pair swap failed");
  chk_swap_banks: assert property (@(posedge mclk) disable iff (!resetn)
    (st == S_OPND && !rd && got >= need && pfx == 8'h00 && op == OP_SWAP_BANKS)
    |=> (hl == $past(hl_alt) && de == $past(de_alt) && bc == $past(bc_alt)))
    else $error("bank swap failed");
  chk_blk_count: assert property (@(posedge mclk) disable iff (!resetn)
    (st == S_BLKRD && rd) |=> (bc == $past(bc) - 16'h0001))
    else $error("byte counter not decremented");
  chk_copy_write: assert property (@(posedge mclk) disable iff (!resetn)
    (st == S_BLKRD && rd && !blk_sel[0]) |=> (mem_wr && mem_addr == de))
    else $error("copy did not write to target");
  chk_repeat_stop: assert property (@(posedge mclk) disable iff (!resetn)
    (st == S_BLKWR && blk_sel[4] && bc == 16'h0000) |=> (st == S_FETCH))
    else $error("repeat copy ran past zero count");
  chk_search_match: assert property (@(posedge mclk) disable iff (!resetn)
    (st == S_BLKRD && rd && blk_sel[0] && mem_rdata == af[15:8])
    |=> (st == S_FETCH && af[MATCH_BIT]))
    else $error("search did not stop on match");
  chk_low_first: assert property (@(posedge mclk) disable iff (!resetn)
    (st == S_OPND && rd && got == 2'd1)
    |=> (opnd == {$past(mem_rdata), $past(opnd[7:0])}))
    else $error("operand bytes not taken low then high");
endmodule

// ---- verification/memory_model.sv ----
`timescale 1ns/1ps
module memory_model (
  // clock
  input  wire logic        mclk,
  // bus from the decoder
  input  wire logic [15:0] mem_addr,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [7:0]  mem_wdata,
  output logic      [7:0]  mem_rdata
);
  logic [7:0] ram [0:65535];

  initial begin
    foreach (ram[i]) begin
      ram[i] = 8'h00;
    end
  end

  // the decoder takes read data at the edge that closes its mem_rd cycle, so data
  // must stand during that cycle; outside reads the line shows the inverse
  assign mem_rdata = mem_rd ? ram[mem_addr] : ~ram[mem_addr];

  always @(posedge mclk) begin
    if (mem_wr) begin
      ram[mem_addr] <= mem_wdata;
    end
  end
endmodule

// ---- verification/load_exchange_block_ops_bench.sv ----
`timescale 1ns/1ps
module load_exchange_block_ops_bench;
  import ldx_pkg::*;
  logic        mclk;
  logic        resetn;
  logic [15:0] mem_addr;
  logic        mem_rd;
  logic        mem_wr;
  logic [7:0]  mem_wdata;
  logic [7:0]  mem_rdata;
  logic        opcode_fetch_cycle;
  logic [15:0] source_pointer_pair;
  logic [15:0] target_pointer_pair;
  logic [15:0] byte_count_pair;
  logic [15:0] accumulator_flags_pair;
  logic [23:0] wlog [$];
  logic [7:0]  model [0:127];
  int          mismatches;
  int          compares;
  int          cycles;
  int          fetches;
  int          prog_fetches;
  int          pc;

  load_exchange_block_ops uut (.mclk, .resetn, .mem_addr, .mem_rd, .mem_wr, .mem_wdata,
    .mem_rdata, .opcode_fetch_cycle, .source_pointer_pair, .target_pointer_pair,
    .byte_count_pair, .accumulator_flags_pair);
  memory_model mem (.mclk, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata);

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      results();
    end
  end

  // sampled on the edge, so the log never races the decoder's own updates
  always @(posedge mclk) begin
    if (resetn === 1'b1 && mem_wr === 1'b1) begin
      wlog.push_back({mem_addr, mem_wdata});
    end
    if (resetn === 1'b1 && mem_rd === 1'b1 && opcode_fetch_cycle === 1'b1) begin
      fetches++;
    end
  end

  task automatic results();
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic put(input logic [7:0] b [$]);
    foreach (b[i]) begin
      mem.ram[16'(pc)] = b[i];
      pc++;
    end
  endtask

  // runs the program from reset until the fetch of the byte after it
  task automatic run();
    int n;
    mem.ram[16'(pc)] = 8'h00;
    mem.ram[16'(pc + 1)] = 8'h00;
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (5) @(posedge mclk);
    wlog.delete();
    fetches = 0;
    resetn <= 1'b1;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (!(mem_rd === 1'b1 && opcode_fetch_cycle === 1'b1 && mem_addr === 16'(pc))
               && n < 3000);
    chk(16'(n < 3000), 16'h0001);
    prog_fetches = fetches;
    @(negedge mclk);
  endtask

  initial begin
    logic [15:0] a, b, c;
    logic [7:0]  k, op, byte_v;
    logic [7:0]  cops [4];
    logic [7:0]  sops [4];
    int          n, s, d, moved, kpos, steps;
    int unsigned seed;
    resetn = 1'b0;
    seed = $urandom(32'h35d7);
    cops = '{OP_COPY_UP, OP_COPY_RUP, OP_COPY_DN, OP_COPY_RDN};
    sops = '{OP_SRCH_UP, OP_SRCH_RUP, OP_SRCH_DN, OP_SRCH_RDN};
    a = 16'($urandom);
    b = 16'($urandom);
    c = 16'($urandom);
    k = 8'($urandom);
    // forms that are only length-decoded sit between loads that must still land
    pc = 0;
    put('{OP_PREFIX_IX, OP_ST_IDX_IMM, 8'h7f, 8'h5a, OP_LD_HL_ABS, 8'h76, 8'h98});
    put('{8'h21, a[7:0], a[15:8], OP_PREFIX_EXT, 8'h4b, 8'h34, 8'h12});
    put('{8'h11, b[7:0], b[15:8], OP_PREFIX_IY, 8'h7e, 8'h05, 8'h01, c[7:0], c[15:8], 8'h3e, k});
    run();
    chk(source_pointer_pair, a);
    chk(target_pointer_pair, b);
    chk(byte_count_pair, c);
    chk({8'h00, accumulator_flags_pair[15:8]}, {8'h00, k});
    a = {8'h81, 1'b0, 7'($urandom)};
    b = {8'h92, 1'b0, 7'($urandom)};
    k = 8'($urandom) | 8'h01;
    mem.ram[a] = k;
    pc = 0;
    put('{OP_LD_A_ABS, a[7:0], a[15:8], OP_ST_A_ABS, b[7:0], b[15:8]});
    run();
    chk({8'h00, accumulator_flags_pair[15:8]}, {8'h00, k});
    chk({8'h00, mem.ram[b]}, {8'h00, k});
    pc = 0;
    put('{8'h3e, k, OP_PUSH_AF, 8'hc1});
    run();
    chk(16'(wlog.size()), 16'h0002);
    chk(wlog[0][23:8], RESET_SP - 16'h0001);
    chk({8'h00, wlog[0][7:0]}, {8'h00, k});
    chk(wlog[1][23:8], RESET_SP - 16'h0002);
    chk(byte_count_pair, {k, 8'h00});
    chk(16'(prog_fetches), 16'h0003);
    a = 16'($urandom) | 16'h0101;
    pc = 0;
    put('{8'h3e, k, OP_SWAP_AF, 8'h3e, ~k, OP_SWAP_AF, 8'h21, a[7:0], a[15:8]});
    put('{8'h11, a[15:8], a[7:0], 8'h01, a[7:0], a[7:0], OP_SWAP_BANKS});
    put('{8'h21, 8'h00, 8'h00, 8'h11, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, OP_SWAP_BANKS});
    run();
    chk({8'h00, accumulator_flags_pair[15:8]}, {8'h00, k});
    chk(source_pointer_pair, a);
    chk(target_pointer_pair, {a[7:0], a[15:8]});
    chk(byte_count_pair, {a[7:0], a[7:0]});
    for (int t = 0; t < 8; t++) begin
      op = cops[t % 4];
      n = (t < 4) ? 1 : 2 + $urandom % 23;
      moved = op[4] ? n : 1;
      s = 16 + $urandom % 16 + (op[3] ? 48 : 0);
      d = 16 + $urandom % 32 + (op[3] ? 48 : 0);
      for (int i = 0; i < 128; i++) begin
        model[i] = 8'($urandom);
        mem.ram[16'h8000 + i] = model[i];
      end
      // byte-serial reference, so overlapping blocks come out as the hardware moves them
      for (int i = 0; i < moved; i++) begin
        model[op[3] ? d - i : d + i] = model[op[3] ? s - i : s + i];
      end
      pc = 0;
      put('{8'h21, 8'(s), 8'h80, 8'h11, 8'(d), 8'h80, 8'h01, 8'(n), 8'h00, OP_PREFIX_EXT, op});
      run();
      chk(byte_count_pair, 16'(n - moved));
      chk(source_pointer_pair, 16'h8000 + 16'(op[3] ? s - moved : s + moved));
      chk(target_pointer_pair, 16'h8000 + 16'(op[3] ? d - moved : d + moved));
      chk(16'(wlog.size()), 16'(moved));
      chk(wlog[0][23:8], 16'h8000 + 16'(d));
      for (int i = 0; i < 128; i++) begin
        chk({8'h00, mem.ram[16'h8000 + i]}, {8'h00, model[i]});
      end
    end
    for (int t = 0; t < 8; t++) begin
      op = sops[t % 4];
      n = 1 + $urandom % 16;
      kpos = (t < 4) ? (op[4] ? n - 1 : 0) : $urandom % (n + 3);
      s = op[3] ? 100 : 20;
      k = 8'($urandom);
      for (int i = 0; i < 128; i++) begin
        byte_v = 8'($urandom);
        mem.ram[16'ha000 + i] = (byte_v == k) ? ~k : byte_v;
      end
      mem.ram[16'ha000 + (op[3] ? s - kpos : s + kpos)] = k;
      steps = op[4] ? ((kpos < n) ? kpos + 1 : n) : 1;
      pc = 0;
      put('{8'h3e, k, 8'h21, 8'(s), 8'ha0, 8'h01, 8'(n), 8'h00, OP_PREFIX_EXT, op});
      run();
      chk(byte_count_pair, 16'(n - steps));
      chk(source_pointer_pair, 16'ha000 + 16'(op[3] ? s - steps : s + steps));
      chk({15'h0000, accumulator_flags_pair[MATCH_BIT]}, {15'h0000, kpos < steps});
    end
    results();
  end
endmodule
